// ===== include/com_pkg.sv
// Purpose: Constants and types for the crane overspeed and speed range monitor
// Assumes: Speeds and frequencies are unsigned, 0.01 Hz per LSB; times in ms
// Notes: Register offsets are APB byte addresses
package com_pkg;
   localparam int COM_CLK_MHZ = 200;
   localparam int COM_TICK_US = 1000;
   localparam int COM_TICK_CYCLES = COM_TICK_US * COM_CLK_MHZ;
   localparam logic [7:0] COM_ADDR_MASK = 8'h00;
   localparam logic [7:0] COM_ADDR_OS_LEVEL = 8'h04;
   localparam logic [7:0] COM_ADDR_OS_TIME = 8'h08;
   localparam logic [7:0] COM_ADDR_SR_PCT = 8'h0C;
   localparam logic [7:0] COM_ADDR_SR_TIME = 8'h10;
   localparam logic [7:0] COM_ADDR_REF_FREQ = 8'h14;
   localparam logic [7:0] COM_ADDR_STATUS = 8'h18;
   localparam logic [7:0] COM_ADDR_CODE = 8'h1C;
   localparam logic [7:0] COM_ADDR_IRQ_STAT = 8'h20;
   localparam logic [7:0] COM_ADDR_IRQ_EN = 8'h24;
   localparam logic [7:0] COM_ADDR_IRQ_CLR = 8'h28;
   localparam int COM_OS_BIT = 0;
   localparam int COM_SR_BIT = 1;
   localparam int COM_FAIL_BIT = 2;
   localparam logic [15:0] COM_MASK_RESET = 16'hFFFF;
   localparam logic [15:0] COM_OS_LEVEL_RESET = 16'hFFFF;
   localparam logic [15:0] COM_TIME_RESET = 16'h0000;
   localparam logic [15:0] COM_PCT_OFF = 16'h270F;
   localparam logic [15:0] COM_REF_FREQ_RESET = 16'h0000;
   localparam logic [31:0] COM_PCT_DIV = 32'h0000_0064;
   localparam logic [7:0] COM_CODE_NONE = 8'h00;
   localparam logic [7:0] COM_CODE_OS = 8'h01;
   localparam logic [7:0] COM_CODE_SR = 8'h02;
   typedef enum logic [1:0] {
      COM_CM_VECTOR,
      COM_CM_SENSORLESS,
      COM_CM_FLUX,
      COM_CM_VF
   } com_ctrl_method_t;
   typedef struct packed {
      logic [15:0] motorSpeed;
      logic [15:0] outputFreq;
      logic [15:0] estSpeed;
      logic [15:0] craneSpeed;
   } com_speeds_t;
   typedef struct packed {
      logic running;
      logic posFeed;
      logic meterFault;
      logic meterAlarm;
      com_ctrl_method_t ctrlMethod;
   } com_drive_t;
endpackage

// ===== logic/com_persist_timer.sv
// Purpose: Persistence timer counting ms ticks while a condition holds
// Assumes: tick is a one-cycle pulse once per ms on core_clk
// Notes: expired is combinational from count and condition
`timescale 1ns/10ps
`default_nettype none
module com_persist_timer
(
   input wire logic core_clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic tick,
   input wire logic cond,
   input wire logic [15:0] limit,
   output logic expired
);
   import com_pkg::*;
   logic [15:0] elapsed;

   always_ff @(posedge core_clk)
   begin
      if (srst)
         elapsed <= 16'h0000;
      else if (ce)
      begin
         if (!cond)
            elapsed <= 16'h0000;
         else if (tick && elapsed != 16'hFFFF)
            elapsed <= elapsed + 16'h0001;
      end
   end

   assign expired = cond && (elapsed >= limit);
endmodule
`default_nettype wire

// ===== logic/com_range_thresh.sv
// Purpose: Speed range excess threshold from reference and percentage
// Assumes: Settings change rarely; one cycle of latency is harmless
// Notes: Result kept at 32 bits so no overflow is possible
`timescale 1ns/10ps
`default_nettype none
module com_range_thresh
(
   input wire logic core_clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic [15:0] refFreq,
   input wire logic [15:0] percent,
   output logic [31:0] threshold
);
   import com_pkg::*;
   logic [31:0] product;

   assign product = {16'h0000, refFreq} * {16'h0000, percent};

   always_ff @(posedge core_clk)
   begin
      if (srst)
         threshold <= 32'h0000_0000;
      else if (ce)
         threshold <= product / COM_PCT_DIV;
   end
endmodule
`default_nettype wire

// ===== logic/com_monitor.sv
// Purpose: Crane overspeed and speed range excess failure monitor, APB slave
// Assumes: Speeds and drive state come from logic on core_clk, no sync needed
// Notes: Crane speed input is already filtered upstream
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module com_monitor
#(
   parameter int unsigned TICK_CYCLES = com_pkg::COM_TICK_CYCLES
)
(
   input wire logic core_clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire com_pkg::com_speeds_t speeds,
   input wire com_pkg::com_drive_t drive,
   output logic failureOutputSignal,
   output logic [15:0] failureCode,
   output logic irq
);
   import com_pkg::*;

   logic [15:0] failureDetectEnableMask;
   logic [15:0] overspeedLevel;
   logic [15:0] overspeedPersistTime;
   logic [15:0] speedRangePercent;
   logic [15:0] speedRangePersistTime;
   logic [15:0] referenceFrequency;
   logic [1:0] irqStatus;
   logic [1:0] irqEnable;
   logic overspeedFail;
   logic rangeFail;
   logic [31:0] tickCount;
   logic tick;
   logic vectorLike;
   logic meterOk;
   logic osEnable;
   logic srEnable;
   logic [15:0] osSpeed;
   logic [15:0] srSpeed;
   logic [15:0] rangeDiff;
   logic [31:0] rangeThreshold;
   logic [1:0] cond;
   logic [1:0] expired;
   logic [15:0] limitVal [2];
   logic osHit;
   logic srHit;
   logic setupPhase;
   logic writeTaken;
   logic [1:0] irqClear;

   // Address decode shared by read and write paths
   function automatic logic addrMapped(input logic [7:0] a);
      logic hit;
      hit = 1'b0;
      if (a == COM_ADDR_MASK)
         hit = 1'b1;
      else if (a == COM_ADDR_OS_LEVEL)
         hit = 1'b1;
      else if (a == COM_ADDR_OS_TIME)
         hit = 1'b1;
      else if (a == COM_ADDR_SR_PCT)
         hit = 1'b1;
      else if (a == COM_ADDR_SR_TIME)
         hit = 1'b1;
      else if (a == COM_ADDR_REF_FREQ)
         hit = 1'b1;
      else if (a == COM_ADDR_STATUS)
         hit = 1'b1;
      else if (a == COM_ADDR_CODE)
         hit = 1'b1;
      else if (a == COM_ADDR_IRQ_STAT)
         hit = 1'b1;
      else if (a == COM_ADDR_IRQ_EN)
         hit = 1'b1;
      else if (a == COM_ADDR_IRQ_CLR)
         hit = 1'b1;
      return hit;
   endfunction

   // Vector control or sensorless vector control
   function automatic logic isVectorMode(input com_ctrl_method_t m);
      return (m == COM_CM_VECTOR) || (m == COM_CM_SENSORLESS);
   endfunction

   // Millisecond tick for the persistence timers
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         tickCount <= 32'h0000_0000;
         tick <= 1'b0;
      end
      else if (ce)
      begin
         if (tickCount >= TICK_CYCLES - 32'd1)
         begin
            tickCount <= 32'h0000_0000;
            tick <= 1'b1;
         end
         else
         begin
            tickCount <= tickCount + 32'h0000_0001;
            tick <= 1'b0;
         end
      end
   end

   assign vectorLike = isVectorMode(drive.ctrlMethod);
   assign meterOk = !drive.meterFault && !drive.meterAlarm;

   // Speed feed allows only vector modes; position feed also flux/VF with healthy meter
   assign osEnable = failureDetectEnableMask[COM_OS_BIT]
      && drive.running
      && (vectorLike || (drive.posFeed && meterOk));

   always_comb
   begin
      case (drive.ctrlMethod)
         COM_CM_VECTOR: osSpeed = speeds.motorSpeed;
         COM_CM_SENSORLESS: osSpeed = speeds.outputFreq;
         default: osSpeed = speeds.craneSpeed;
      endcase
   end

   assign srEnable = failureDetectEnableMask[COM_SR_BIT]
      && drive.running
      && drive.posFeed
      && meterOk
      && (speedRangePercent != COM_PCT_OFF)
      && vectorLike;

   always_comb
   begin
      if (drive.ctrlMethod == COM_CM_VECTOR)
         srSpeed = speeds.motorSpeed;
      else
         srSpeed = speeds.estSpeed;
   end

   assign rangeDiff = (srSpeed >= speeds.craneSpeed)
      ? srSpeed - speeds.craneSpeed
      : speeds.craneSpeed - srSpeed;

   com_range_thresh u_thresh
   (
      .core_clk(core_clk),
      .srst(srst),
      .ce(ce),
      .refFreq(referenceFrequency),
      .percent(speedRangePercent),
      .threshold(rangeThreshold)
   );

   assign cond[COM_OS_BIT] = osEnable && (osSpeed > overspeedLevel);
   assign cond[COM_SR_BIT] = srEnable && ({16'h0000, rangeDiff} > rangeThreshold);
   assign limitVal[COM_OS_BIT] = overspeedPersistTime;
   assign limitVal[COM_SR_BIT] = speedRangePersistTime;

   // One persistence timer per failure kind
   generate
      for (genvar i = 0; i < 2; i++)
      begin : g_timer
         com_persist_timer u_timer
         (
            .core_clk(core_clk),
            .srst(srst),
            .ce(ce),
            .tick(tick),
            .cond(cond[i]),
            .limit(limitVal[i]),
            .expired(expired[i])
         );
      end
   endgenerate

   assign osHit = expired[COM_OS_BIT] && !overspeedFail;
   assign srHit = expired[COM_SR_BIT] && !rangeFail;

   // Failure latches, cleared only by drive reset
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         overspeedFail <= 1'b0;
         rangeFail <= 1'b0;
      end
      else if (ce)
      begin
         if (osHit)
            overspeedFail <= 1'b1;
         if (srHit)
            rangeFail <= 1'b1;
      end
   end

   // First failure code; overspeed wins a tie
   always_ff @(posedge core_clk)
   begin
      if (srst)
         failureCode <= {COM_CODE_NONE, COM_CODE_NONE};
      else if (ce && failureCode[7:0] == COM_CODE_NONE)
      begin
         if (osHit)
            failureCode <= {COM_CODE_NONE, COM_CODE_OS};
         else if (srHit)
            failureCode <= {COM_CODE_NONE, COM_CODE_SR};
      end
   end

   assign failureOutputSignal = overspeedFail || rangeFail;

   // APB: pready follows ce, so the access phase waits while ce is low; data prepared in setup
   assign setupPhase = psel && !penable;
   assign pready = ce;
   assign writeTaken = ce && psel && penable && pwrite && addrMapped(paddr);
   assign irqClear = (writeTaken && paddr == COM_ADDR_IRQ_CLR) ? pwdata[1:0] : 2'b00;

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         failureDetectEnableMask <= COM_MASK_RESET;
         overspeedLevel <= COM_OS_LEVEL_RESET;
         overspeedPersistTime <= COM_TIME_RESET;
         speedRangePercent <= COM_PCT_OFF;
         speedRangePersistTime <= COM_TIME_RESET;
         referenceFrequency <= COM_REF_FREQ_RESET;
         irqEnable <= 2'b00;
      end
      else if (writeTaken)
      begin
         if (paddr == COM_ADDR_MASK)
            failureDetectEnableMask <= pwdata[15:0];
         else if (paddr == COM_ADDR_OS_LEVEL)
            overspeedLevel <= pwdata[15:0];
         else if (paddr == COM_ADDR_OS_TIME)
            overspeedPersistTime <= pwdata[15:0];
         else if (paddr == COM_ADDR_SR_PCT)
            speedRangePercent <= pwdata[15:0];
         else if (paddr == COM_ADDR_SR_TIME)
            speedRangePersistTime <= pwdata[15:0];
         else if (paddr == COM_ADDR_REF_FREQ)
            referenceFrequency <= pwdata[15:0];
         else if (paddr == COM_ADDR_IRQ_EN)
            irqEnable <= pwdata[1:0];
      end
   end

   // Sticky event bits; a new event beats a clear in the same cycle
   always_ff @(posedge core_clk)
   begin
      if (srst)
         irqStatus <= 2'b00;
      else if (ce)
         irqStatus <= (irqStatus & ~irqClear) | {srHit, osHit};
   end

   assign irq = |(irqStatus & irqEnable);

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else if (ce && setupPhase)
      begin
         pslverr <= !addrMapped(paddr);
         if (pwrite)
            prdata <= 32'h0000_0000;
         else if (paddr == COM_ADDR_MASK)
            prdata <= {16'h0000, failureDetectEnableMask};
         else if (paddr == COM_ADDR_OS_LEVEL)
            prdata <= {16'h0000, overspeedLevel};
         else if (paddr == COM_ADDR_OS_TIME)
            prdata <= {16'h0000, overspeedPersistTime};
         else if (paddr == COM_ADDR_SR_PCT)
            prdata <= {16'h0000, speedRangePercent};
         else if (paddr == COM_ADDR_SR_TIME)
            prdata <= {16'h0000, speedRangePersistTime};
         else if (paddr == COM_ADDR_REF_FREQ)
            prdata <= {16'h0000, referenceFrequency};
         else if (paddr == COM_ADDR_STATUS)
            prdata <= {29'h0000_0000, failureOutputSignal, rangeFail, overspeedFail};
         else if (paddr == COM_ADDR_CODE)
            prdata <= {16'h0000, failureCode};
         else if (paddr == COM_ADDR_IRQ_STAT)
            prdata <= {30'h0000_0000, irqStatus};
         else if (paddr == COM_ADDR_IRQ_EN)
            prdata <= {30'h0000_0000, irqEnable};
         else
            prdata <= 32'h0000_0000;
      end
   end
endmodule
`default_nettype wire

// ===== tb/com_monitor_checker.sv
// Purpose: Port assertions for the crane failure monitor
// Assumes: One clock, srst disables every check
// Notes: Bound into com_monitor below
`timescale 1ns/10ps
`default_nettype none
module com_monitor_checker
(
   input wire logic core_clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic pready,
   input wire com_pkg::com_drive_t drive,
   input wire logic failureOutputSignal,
   input wire logic [15:0] failureCode,
   input wire logic irq
);
   import com_pkg::*;
   default clocking dc @(posedge core_clk);
   endclocking
   default disable iff (srst);
   a_fail_sticky: assert property (failureOutputSignal |=> failureOutputSignal)
      else $error("failure output dropped");
   a_code_hold: assert property (failureCode != 16'h0000 |=> $stable(failureCode))
      else $error("failure code changed");
   a_out_code: assert property (failureOutputSignal == (failureCode != 16'h0000))
      else $error("failure output and code disagree");
   a_code_legal: assert property (failureCode inside {16'h0000, 16'h0001, 16'h0002})
      else $error("failure code out of range");
   a_idle_quiet: assert property (!drive.running && !failureOutputSignal
      |=> !failureOutputSignal)
      else $error("failure raised while stopped");
   a_speed_feed: assert property (!drive.posFeed && drive.ctrlMethod[1] && !failureOutputSignal
      |=> !failureOutputSignal)
      else $error("failure raised in speed feed flux mode");
   a_meter_bad: assert property ((drive.meterFault || drive.meterAlarm)
      && drive.ctrlMethod[1] && !failureOutputSignal |=> !failureOutputSignal)
      else $error("failure raised with bad meter");
   a_range_cause: assert property ($rose(failureCode[1])
      |-> $past(drive.posFeed) && !$past(drive.ctrlMethod[1]))
      else $error("range failure without its enables");
   a_irq_cause: assert property (irq |-> failureOutputSignal)
      else $error("interrupt without failure");
   a_ready_ce: assert property (pready == ce)
      else $error("ready does not follow clock enable");
   c_overspeed: cover property ($rose(failureCode[0]));
   c_range: cover property ($rose(failureCode[1]));
   c_irq: cover property ($rose(irq));
endmodule
bind com_monitor com_monitor_checker uChk (.core_clk, .srst, .ce, .pready, .drive,
   .failureOutputSignal, .failureCode, .irq);
`default_nettype wire

// ===== tb/com_drive_model.sv
// Purpose: Drive loop and distance meter data source
// Assumes: Bench states the wanted speeds and drive state
// Notes: Values appear one cycle later; a failing meter gives noisy crane speed
`timescale 1ns/10ps
`default_nettype none
module com_drive_model
(
   input wire logic core_clk,
   input wire com_pkg::com_speeds_t wantSpeeds,
   input wire com_pkg::com_drive_t wantDrive,
   output var com_pkg::com_speeds_t speeds,
   output var com_pkg::com_drive_t drive
);
   import com_pkg::*;
   always_ff @(posedge core_clk)
   begin
      drive <= wantDrive;
      // Unreliable distance data
      if (wantDrive.meterFault || wantDrive.meterAlarm)
         speeds <= {wantSpeeds[63:16], ~speeds.craneSpeed};
      else
         speeds <= wantSpeeds;
   end
endmodule
`default_nettype wire

// ===== tb/com_monitor_tb_top.sv
// Purpose: Self-checking bench for the crane failure monitor
// Assumes: Tick shortened to 4 cycles; ce dropped once to test freezing
// Notes: Table rows cover modes; hand tests cover timing, irq, APB, reset
`timescale 1ns/10ps
`default_nettype none
module com_monitor_tb_top;
   import com_pkg::*;
   typedef struct packed {
      logic [1:0] mask;
      logic [15:0] pct;
      com_drive_t drv;
      com_speeds_t spd;
      logic [7:0] code;
   } com_row_t;
   localparam com_row_t ROWS [0:14] = '{
      {2'h3, 16'h000A, 6'h30, 64'h04B0_0000_0000_04B0, 8'h01},
      {2'h3, 16'h000A, 6'h31, 64'h0000_04B0_04B0_04B0, 8'h01},
      {2'h3, 16'h000A, 6'h32, 64'h0000_0000_0000_04B0, 8'h01},
      {2'h3, 16'h000A, 6'h37, 64'h0000_0000_0000_04B0, 8'h00},
      {2'h3, 16'h000A, 6'h22, 64'h0000_0000_0000_04B0, 8'h00},
      {2'h3, 16'h000A, 6'h10, 64'h04B0_0000_0000_04B0, 8'h00},
      {2'h2, 16'h000A, 6'h30, 64'h04B0_0000_0000_04B0, 8'h00},
      {2'h3, 16'h000A, 6'h30, 64'h0384_04B0_0000_012C, 8'h02},
      {2'h3, 16'h000A, 6'h31, 64'h04B0_0000_0384_012C, 8'h02},
      {2'h1, 16'h000A, 6'h30, 64'h0384_0000_0000_012C, 8'h00},
      {2'h3, 16'h270F, 6'h30, 64'h0384_0000_0000_012C, 8'h00},
      {2'h3, 16'h000A, 6'h20, 64'h0384_0000_0000_012C, 8'h00},
      {2'h3, 16'h000A, 6'h30, 64'h0320_0000_0000_012C, 8'h00},
      {2'h3, 16'h000A, 6'h30, 64'h0321_0000_0000_012C, 8'h02},
      {2'h3, 16'h000A, 6'h34, 64'h0384_0000_0000_012C, 8'h00}};
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic ce = 1'b1;
   logic [7:0] paddr = 8'h00;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   com_speeds_t wantSpeeds = '0;
   com_drive_t wantDrive = '0;
   com_speeds_t speeds;
   com_drive_t drive;
   logic failureOutputSignal;
   logic [15:0] failureCode;
   logic irq;
   logic [31:0] rd;
   int errCount = 0;
   int checksDone = 0;
   always #2.5 core_clk = ~core_clk;
   com_monitor #(.TICK_CYCLES(4)) uut (.core_clk, .srst, .ce, .paddr, .psel, .penable,
      .pwrite, .pwdata, .prdata, .pready, .pslverr, .speeds, .drive,
      .failureOutputSignal, .failureCode, .irq);
   com_drive_model model (.core_clk, .wantSpeeds, .wantDrive, .speeds, .drive);
   task automatic giveVerdict();
      $display("checks %0d mismatches %0d", checksDone, errCount);
      if (errCount == 0 && checksDone > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checksDone++;
      if (got !== exp)
      begin
         errCount++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge core_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1)
      begin
         errCount++;
         giveVerdict();
      end
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      cmp(rd, e);
   endtask
   task automatic doReset(input int cyc);
      srst <= 1'b1;
      repeat (cyc) @(posedge core_clk);
      srst <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic setup(input logic [15:0] mask, input logic [15:0] pct, input logic [15:0] t);
      apb(1'b1, COM_ADDR_MASK, {16'h0000, mask});
      apb(1'b1, COM_ADDR_OS_LEVEL, 32'h0000_03E8);
      apb(1'b1, COM_ADDR_OS_TIME, {16'h0000, t});
      apb(1'b1, COM_ADDR_SR_PCT, {16'h0000, pct});
      apb(1'b1, COM_ADDR_REF_FREQ, 32'h0000_1389);
   endtask
   initial
   begin
      doReset(10);
      rdChk(COM_ADDR_MASK, 32'h0000_FFFF);
      rdChk(COM_ADDR_SR_PCT, 32'h0000_270F);
      rdChk(COM_ADDR_OS_LEVEL, 32'h0000_FFFF);
      foreach (ROWS[i])
      begin
         doReset(2);
         setup({14'h0000, ROWS[i].mask}, ROWS[i].pct, 16'h0000);
         wantDrive <= ROWS[i].drv;
         wantSpeeds <= ROWS[i].spd;
         repeat (6) @(posedge core_clk);
         cmp({24'h0, failureCode[7:0]}, {24'h0, ROWS[i].code});
         cmp({31'h0, failureOutputSignal}, {31'h0, |ROWS[i].code});
         wantDrive <= '0;
         $display("row %0d done", i);
      end
      doReset(2);
      setup(16'h0002, 16'h000A, 16'h0000);
      apb(1'b1, COM_ADDR_SR_TIME, 32'h0000_0002);
      rdChk(COM_ADDR_SR_TIME, 32'h0000_0002);
      cmp({31'h0, pslverr}, 32'h0);
      wantSpeeds <= 64'h0384_0000_0000_012C;
      wantDrive <= 6'h30;
      ce <= 1'b0;
      repeat (12) @(posedge core_clk);
      cmp({31'h0, failureOutputSignal}, 32'h0);
      cmp({31'h0, pready}, 32'h0);
      ce <= 1'b1;
      repeat (3) @(posedge core_clk);
      cmp({31'h0, failureOutputSignal}, 32'h0);
      repeat (10) @(posedge core_clk);
      cmp({16'h0, failureCode}, 32'h0000_0002);
      cmp({31'h0, failureOutputSignal}, 32'h1);
      wantDrive <= '0;
      $display("range time and clock enable test done");
      doReset(2);
      setup(16'h0001, 16'h270F, 16'h0003);
      wantSpeeds <= 64'h04B0_0000_0000_0000;
      repeat (2)
      begin
         wantDrive <= 6'h30;
         repeat (8) @(posedge core_clk);
         wantDrive <= '0;
         repeat (2) @(posedge core_clk);
      end
      cmp({31'h0, failureOutputSignal}, 32'h0);
      wantDrive <= 6'h30;
      repeat (20) @(posedge core_clk);
      wantDrive <= '0;
      repeat (4) @(posedge core_clk);
      cmp({16'h0, failureCode}, 32'h0000_0001);
      cmp({31'h0, irq}, 32'h0);
      $display("persistence test done");
      apb(1'b1, COM_ADDR_IRQ_EN, 32'h0000_0001);
      cmp({31'h0, irq}, 32'h1);
      rdChk(COM_ADDR_STATUS, 32'h0000_0005);
      apb(1'b1, COM_ADDR_IRQ_CLR, 32'h0000_0001);
      cmp({31'h0, irq}, 32'h0);
      rdChk(COM_ADDR_IRQ_STAT, 32'h0);
      rdChk(8'h30, 32'h0);
      cmp({31'h0, pslverr}, 32'h1);
      $display("irq and bus test done");
      doReset(2);
      cmp({15'h0, failureOutputSignal, failureCode}, 32'h0);
      $display("reset test done");
      giveVerdict();
   end
endmodule
`default_nettype wire
